// ### verif/pss_bus_master.sv
// Two-wire bus master model: start, write bytes, stop.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module pss_bus_master
    import pss_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sda_pin,
    output logic      scl_pin,
    output logic      sda_low
);
    ////////////////////////////////////////////////////////////////////////////
    // Clock idles high between frames, so a sync glitch cannot fake a start
    initial begin
        scl_pin = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // 16 cycles per half bit, well above the 2-FF latency
    task automatic bit_io(input logic d, output logic seen);
        scl_pin <= 1'b0;
        tick(4);
        sda_low <= ~d;
        tick(12);
        scl_pin <= 1'b1;
        tick(8);
        seen = sda_pin;
        tick(8);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Unacked byte ends the transfer, as a real master would
    task automatic write(input logic [7:0] sub, input logic [7:0] data,
                         output logic [2:0] acks);
        acks = 3'h0;
        sda_low <= 1'b1;
        tick(16);
        put_byte({DEV_ADDR, 1'b0}, acks[2]);
        if (acks[2]) begin
            put_byte(sub, acks[1]);
        end
        if (acks[1]) begin
            put_byte(data, acks[0]);
        end
        scl_pin <= 1'b0;
        tick(4);
        sda_low <= 1'b1;
        tick(12);
        scl_pin <= 1'b1;
        tick(16);
        sda_low <= 1'b0;
        tick(16);
    endtask
endmodule

// ### verif/pss_sequencer_tb.sv
// Self-checking bench of the protection and start-up sequencer.
// Assumes the bus master model drives the bus; supply and fault levels come from here.
`timescale 1ns/1ps
module pss_sequencer_tb;
    import pss_pkg::*;

    localparam logic [6:0] G_OFF = 7'h03;
    localparam logic [6:0] G_RUN = 7'h7C;

    logic     clk_sys;
    logic     arst_n;
    logic     supply_above_8v3;
    logic     supply_above_8v1;
    logic     tube_overvoltage_input;
    logic     phase_loop_filter_pin;
    logic     lock_lost_in;
    logic     scl_pin;
    logic     sda_low;
    logic     sda_oe;
    wire      sda_pin;
    pss_drv_t gated_out;
    pss_seq_t seq_state;
    int       n_errors;
    int       n_checks;

    // Pull-up on the data wire
    assign sda_pin = ~(sda_oe | sda_low);

    ////////////////////////////////////////////////////////////////////////////
    pss_sequencer pss_sequencer_inst (
        .clk_sys                (clk_sys),
        .arst_n                 (arst_n),
        .scl_pin                (scl_pin),
        .sda_pin                (sda_pin),
        .sda_oe                 (sda_oe),
        .supply_above_8v3       (supply_above_8v3),
        .supply_above_8v1       (supply_above_8v1),
        .tube_overvoltage_input (tube_overvoltage_input),
        .phase_loop_filter_pin  (phase_loop_filter_pin),
        .lock_lost_in           (lock_lost_in),
        .gated_out              (gated_out),
        .seq_state              (seq_state)
    );

    pss_bus_master pss_bus_master_inst (
        .clk_sys (clk_sys),
        .sda_pin (sda_pin),
        .scl_pin (scl_pin),
        .sda_low (sda_low)
    );

    always #2 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_state(input pss_seq_t s, input int lim);
        int n;
        n = 0;
        while (seq_state !== s && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        check("seq_state", 8'(seq_state), 8'(s));
    endtask

    task automatic bus(input logic [7:0] sub, input logic [7:0] data, input logic [2:0] exp);
        logic [2:0] a;
        pss_bus_master_inst.write(sub, data, a);
        check("bus_acks", 8'(a), 8'(exp));
    endtask

    task automatic set_supply(input logic v);
        supply_above_8v3 <= v;
        supply_above_8v1 <= v;
        tick(8);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        check("gated_out", 8'(gated_out), 8'(G_OFF));
        check("seq_state", 8'(seq_state), 8'(SQ_STANDBY));
        set_supply(1'b0);
        bus(CTRL_SUB, 8'h01, 3'h0);
        check("gated_out", 8'(gated_out), 8'(G_OFF));
        set_supply(1'b1);
        bus(8'h05, 8'hA5, 3'h6);
        tick(300);
        check("seq_state", 8'(seq_state), 8'(SQ_STANDBY));
    endtask

    // About 200 cycles into each 250-cycle step, since soft start begins before the write returns, so a one-cycle slip cannot matter
    task automatic t_soft_start();
        bus(CTRL_SUB, 8'h01, 3'h7);
        wait_state(SQ_SOFTSTART, 20);
        tick(125);
        check("gated_out", 8'(gated_out), 8'h60);
        tick(250);
        check("gated_out", 8'(gated_out), 8'h70);
        tick(250);
        check("gated_out", 8'(gated_out), 8'h78);
        tick(250);
        check("gated_out", 8'(gated_out), 8'(G_RUN));
        wait_state(SQ_ACTIVE, 300);
        bus(8'h03, 8'h55, 3'h7);
    endtask

    task automatic t_loop_filter();
        phase_loop_filter_pin <= 1'b0;
        tick(8);
        check("gated_out", 8'(gated_out), 8'(G_OFF));
        phase_loop_filter_pin <= 1'b1;
        tick(8);
        check("gated_out", 8'(gated_out), 8'(G_RUN));
        check("seq_state", 8'(seq_state), 8'(SQ_ACTIVE));
        // Lock flag alone follows the lock-loss input
        lock_lost_in <= 1'b1;
        tick(2);
        check("gated_out", 8'(gated_out), 8'h78);
        lock_lost_in <= 1'b0;
        tick(2);
        check("gated_out", 8'(gated_out), 8'(G_RUN));
    endtask

    task automatic t_overvoltage();
        tube_overvoltage_input <= 1'b1;
        tick(8);
        check("seq_state", 8'(seq_state), 8'(SQ_PROTECT));
        check("gated_out", 8'(gated_out), 8'(G_OFF));
        tube_overvoltage_input <= 1'b0;
        tick(300);
        check("seq_state", 8'(seq_state), 8'(SQ_PROTECT));
        bus(CTRL_SUB, 8'h01, 3'h7);
        wait_state(SQ_SOFTSTART, 20);
        wait_state(SQ_ACTIVE, 1100);
    endtask

    // Restart by supply alone: the soft-start bit survives a dip from running
    task automatic t_dip();
        set_supply(1'b0);
        check("seq_state", 8'(seq_state), 8'(SQ_PROTECT));
        check("gated_out", 8'(gated_out), 8'(G_OFF));
        bus(CTRL_SUB, 8'h01, 3'h0);
        set_supply(1'b1);
        wait_state(SQ_SOFTSTART, 20);
        wait_state(SQ_ACTIVE, 1100);
    endtask

    task automatic t_standby();
        bus(CTRL_SUB, 8'h02, 3'h7);
        wait_state(SQ_STANDBY, 20);
        tick(8);
        check("gated_out", 8'(gated_out), 8'(G_OFF));
        bus(8'h01, 8'h5A, 3'h6);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        supply_above_8v3 = 1'b1;
        supply_above_8v1 = 1'b1;
        tube_overvoltage_input = 1'b0;
        phase_loop_filter_pin = 1'b1;
        lock_lost_in = 1'b0;
        n_errors = 0;
        n_checks = 0;
        tick(3);
        arst_n <= 1'b1;
        tick(8);
        t_power_up();
        t_soft_start();
        t_loop_filter();
        t_overvoltage();
        t_dip();
        t_standby();
        end_of_test();
    end

    // About 10k cycles of traffic and soft starts expected
    initial begin
        tick(60000);
        n_errors++;
        end_of_test();
    end
endmodule

// ### verilog/pss_bus_slave.sv
// Write-only two-wire bus slave with acknowledge gating for standby.
// Assumes raw scl/sda pin levels; the data line is open drain, pulled low while sda_oe is high.
`timescale 1ns/1ps
module pss_bus_slave
    import pss_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire logic    arst_n,
    input  wire logic    scl_pin,
    input  wire logic    sda_pin,
    input  wire logic    bus_en,
    input  wire logic    active,
    output logic         sda_oe,
    output pss_wr_t      wr
);
    logic [1:0] scl_s_ff, sda_s_ff, nxt_scl_s, nxt_sda_s;
    logic       scl_d_ff, sda_d_ff, nxt_scl_d, nxt_sda_d;
    pss_phase_t phase_ff, nxt_phase;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh, sub_ff, nxt_sub;
    logic       oe_ff, nxt_oe, ack_ok;
    pss_wr_t    wr_ff, nxt_wr;
    logic       scl_rise, scl_fall, start, stop;

    ////////////////////////////////////////////////////////////////////////////
    // Edges only from second sync stage onward
    assign scl_rise = scl_s_ff[1] & ~scl_d_ff;
    assign scl_fall = ~scl_s_ff[1] & scl_d_ff;
    assign start    = scl_s_ff[1] & scl_d_ff & sda_d_ff & ~sda_s_ff[1];
    assign stop     = scl_s_ff[1] & scl_d_ff & ~sda_d_ff & sda_s_ff[1];

    always_comb begin
        unique case (phase_ff)
            PH_IDLE: ack_ok = 1'b0;
            PH_ADDR: ack_ok = bus_en && sh_ff[7:1] == DEV_ADDR && !sh_ff[0];
            PH_SUB:  ack_ok = bus_en;
            PH_DATA: ack_ok = bus_en && (active || sub_ff == CTRL_SUB);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_scl_s = {scl_s_ff[0], scl_pin};
        nxt_sda_s = {sda_s_ff[0], sda_pin};
        nxt_scl_d = scl_s_ff[1];
        nxt_sda_d = sda_s_ff[1];
        nxt_phase = phase_ff;
        nxt_cnt   = cnt_ff;
        nxt_sh    = sh_ff;
        nxt_sub   = sub_ff;
        nxt_oe    = oe_ff;
        nxt_wr    = '0;
        if (start) begin
            nxt_phase = PH_ADDR;
            nxt_cnt   = 4'h0;
            nxt_oe    = 1'b0;
        end else if (stop) begin
            nxt_phase = PH_IDLE;
            nxt_oe    = 1'b0;
        end else if (phase_ff != PH_IDLE) begin
            if (scl_rise) begin
                if (cnt_ff == CNT_ACK) begin
                    nxt_cnt = 4'h0;
                    if (!oe_ff) begin
                        nxt_phase = PH_IDLE;
                    end else begin
                        unique case (phase_ff)
                            PH_IDLE, PH_ADDR: nxt_phase = PH_SUB;
                            PH_SUB: begin
                                nxt_phase = PH_DATA;
                                nxt_sub   = sh_ff;
                            end
                            PH_DATA: nxt_sub = sub_ff + 8'h01;
                        endcase
                    end
                end else begin
                    nxt_sh  = {sh_ff[6:0], sda_s_ff[1]};
                    nxt_cnt = cnt_ff + 4'h1;
                end
            end
            if (scl_fall) begin
                nxt_oe = 1'b0;
                if (cnt_ff == CNT_ACK) begin
                    nxt_oe      = ack_ok;
                    // Data without acknowledge is never stored
                    nxt_wr.stb  = ack_ok && phase_ff == PH_DATA;
                    nxt_wr.sub  = sub_ff;
                    nxt_wr.data = sh_ff;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_s_ff <= 2'h3;
            sda_s_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            phase_ff <= PH_IDLE;
            cnt_ff   <= 4'h0;
            sh_ff    <= 8'h00;
            sub_ff   <= 8'h00;
            oe_ff    <= 1'b0;
            wr_ff    <= '0;
        end else begin
            scl_s_ff <= nxt_scl_s;
            sda_s_ff <= nxt_sda_s;
            scl_d_ff <= nxt_scl_d;
            sda_d_ff <= nxt_sda_d;
            phase_ff <= nxt_phase;
            cnt_ff   <= nxt_cnt;
            sh_ff    <= nxt_sh;
            sub_ff   <= nxt_sub;
            oe_ff    <= nxt_oe;
            wr_ff    <= nxt_wr;
        end
    end

    assign sda_oe = oe_ff;
    assign wr     = wr_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_NO_ACK_LOW_SUPPLY: assert property (
        !bus_en && scl_fall && !start && !stop |=> !oe_ff)
        else $error("acknowledge given with supply low");
    AST_DATA_ACK_ACTIVE: assert property (
        bus_en && active && scl_fall && phase_ff == PH_DATA && cnt_ff == CNT_ACK
        && !start && !stop |=> oe_ff && wr_ff.stb)
        else $error("active data byte not acknowledged");
    AST_STANDBY_OTHER_SUB: assert property (
        !active && scl_fall && phase_ff == PH_DATA && cnt_ff == CNT_ACK
        && sub_ff != CTRL_SUB |=> !oe_ff && !wr_ff.stb)
        else $error("standby data to other subaddress acknowledged");
    AST_STANDBY_CTRL_SUB: assert property (
        bus_en && scl_fall && phase_ff == PH_DATA && cnt_ff == CNT_ACK
        && sub_ff == CTRL_SUB && !start && !stop |=> oe_ff ##0 wr_ff.sub == CTRL_SUB)
        else $error("control subaddress not acknowledged");
endmodule

// ### verilog/pss_pkg.sv
// Constants, types and carriers of the protection and start-up sequencer.
// Assumes one 250 MHz system clock shared by every user of this package.
package pss_pkg;

    // Clock and soft-start step timing
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          SS_STEP_NS    = 1000;
    localparam int          SS_STEP_CYC   = (SS_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  SS_TMR_LAST   = 8'(SS_STEP_CYC - 1);
    localparam logic [1:0]  SS_STEP_LAST  = 2'h3;

    // Serial bus slave; device address value is arbitrary
    localparam logic [6:0]  DEV_ADDR      = 7'h46;
    localparam logic [3:0]  CNT_ACK       = 4'h8;

    // Standby and soft-start control register
    localparam logic [7:0]  CTRL_SUB      = 8'h1A;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam int          SS_BIT        = 0;
    localparam int          STANDBY_BIT   = 1;

    typedef enum logic [1:0] {
        SQ_STANDBY   = 2'b00,
        SQ_SOFTSTART = 2'b01,
        SQ_ACTIVE    = 2'b10,
        SQ_PROTECT   = 2'b11
    } pss_seq_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_SUB  = 2'b10,
        PH_DATA = 2'b11
    } pss_phase_t;

    typedef struct packed {
        logic       stb;
        logic [7:0] sub;
        logic [7:0] data;
    } pss_wr_t;

    typedef struct packed {
        logic dip;
        logic ovp;
    } pss_cause_t;

    typedef struct packed {
        logic vertical_out_a;
        logic vertical_out_b;
        logic horizontal_drive_out;
        logic supply_boost_drive_out;
        logic lock_loss_flag;
        logic clamp_blank_out;
        logic pll_discharge;
    } pss_drv_t;

endpackage

// ### verilog/pss_sequencer.sv
// Protection and start-up sequencer gating the drive outputs of a deflection controller.
// Assumes supply comparators, over-voltage and loop-filter levels arrive asynchronously;
// lock_lost_in comes from logic on clk_sys. Drive enables high mean released to the stage.
`timescale 1ns/1ps
module pss_sequencer
    import pss_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     arst_n,
    input  wire logic     scl_pin,
    input  wire logic     sda_pin,
    output logic          sda_oe,
    input  wire logic     supply_above_8v3,
    input  wire logic     supply_above_8v1,
    input  wire logic     tube_overvoltage_input,
    input  wire logic     phase_loop_filter_pin,
    input  wire logic     lock_lost_in,
    output pss_drv_t      gated_out,
    output pss_seq_t      seq_state
);
    logic [3:0] in_s1_ff, in_s2_ff;
    pss_seq_t   state_ff, nxt_state;
    logic [7:0] reg_ff, nxt_reg;
    pss_cause_t cause_ff, nxt_cause;
    logic [1:0] step_ff, nxt_step;
    logic [7:0] tmr_ff, nxt_tmr;
    pss_drv_t   drv_ff, nxt_drv;
    logic       bus_en_ff, act_ff;
    pss_wr_t    wr;
    logic       sup83, sup81, ovp, pll_low;
    logic       running, soft_wr, run_ok, prot;
    logic [2:0] lvl;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for asynchronous levels
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            in_s1_ff <= 4'h8;
            in_s2_ff <= 4'h8;
        end else begin
            in_s1_ff <= {phase_loop_filter_pin, tube_overvoltage_input,
                         supply_above_8v1, supply_above_8v3};
            in_s2_ff <= in_s1_ff;
        end
    end

    assign sup83   = in_s2_ff[0];
    assign sup81   = in_s2_ff[1];
    assign ovp     = in_s2_ff[2];
    assign pll_low = ~in_s2_ff[3];

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave; acknowledge gating depends on flopped supply and run state
    pss_bus_slave pss_bus_slave_inst (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .scl_pin (scl_pin),
        .sda_pin (sda_pin),
        .bus_en  (bus_en_ff),
        .active  (act_ff),
        .sda_oe  (sda_oe),
        .wr      (wr)
    );

    assign running = state_ff == SQ_SOFTSTART || state_ff == SQ_ACTIVE;
    assign soft_wr = wr.stb && wr.sub == CTRL_SUB;
    assign run_ok  = sup83 && reg_ff[SS_BIT] && !reg_ff[STANDBY_BIT]
                     && cause_ff == '0 && !ovp;

    ////////////////////////////////////////////////////////////////////////////
    // Control register and latched protection causes
    always_comb begin
        nxt_reg   = reg_ff;
        nxt_cause = cause_ff;
        if (soft_wr) begin
            nxt_reg = wr.data;
        end
        // Only standby is reset; a dip keeps the bit so supply can restart
        if (!sup83 && state_ff == SQ_STANDBY) begin
            nxt_reg = CTRL_RST;
        end
        if (soft_wr && wr.data[SS_BIT]) begin
            nxt_cause = '0;
        end
        if (sup83 && reg_ff[SS_BIT]) begin
            nxt_cause.dip = 1'b0;
        end
        // Set wins over any clear in the same cycle
        if (running && !sup81) begin
            nxt_cause.dip = 1'b1;
        end
        if (ovp) begin
            nxt_cause.ovp = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_ff   <= CTRL_RST;
            cause_ff <= '0;
        end else begin
            reg_ff   <= nxt_reg;
            cause_ff <= nxt_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    always_comb begin
        nxt_state = state_ff;
        nxt_step  = step_ff;
        nxt_tmr   = tmr_ff;
        unique case (state_ff)
            SQ_STANDBY: begin
                if (run_ok) begin
                    nxt_state = SQ_SOFTSTART;
                    nxt_step  = 2'h0;
                    nxt_tmr   = 8'h00;
                end
            end
            SQ_SOFTSTART, SQ_ACTIVE: begin
                if (!sup81 || ovp) begin
                    nxt_state = SQ_PROTECT;
                end else if (!reg_ff[SS_BIT] || reg_ff[STANDBY_BIT]) begin
                    nxt_state = SQ_STANDBY;
                end else if (state_ff == SQ_SOFTSTART) begin
                    nxt_tmr = tmr_ff + 8'h01;
                    if (tmr_ff == SS_TMR_LAST) begin
                        nxt_tmr  = 8'h00;
                        nxt_step = step_ff + 2'h1;
                        if (step_ff == SS_STEP_LAST) begin
                            nxt_state = SQ_ACTIVE;
                        end
                    end
                end
            end
            SQ_PROTECT: begin
                // Leave only once every latched and live cause is gone
                if (cause_ff == '0 && !ovp && sup83) begin
                    nxt_state = run_ok ? SQ_SOFTSTART : SQ_STANDBY;
                    nxt_step  = 2'h0;
                    nxt_tmr   = 8'h00;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= SQ_STANDBY;
            step_ff  <= 2'h0;
            tmr_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            step_ff  <= nxt_step;
            tmr_ff   <= nxt_tmr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output gating: vertical, horizontal, boost, then lock flag
    always_comb begin
        unique case (state_ff)
            SQ_ACTIVE:    lvl = 3'h4;
            SQ_SOFTSTART: lvl = {1'b0, step_ff} + 3'h1;
            SQ_STANDBY,
            SQ_PROTECT:   lvl = 3'h0;
        endcase
        // Grounded loop filter forces protection without touching state
        prot = !running || pll_low;
        nxt_drv.vertical_out_a         = !pll_low && lvl > 3'h0;
        nxt_drv.vertical_out_b         = !pll_low && lvl > 3'h0;
        nxt_drv.horizontal_drive_out   = !pll_low && lvl > 3'h1;
        nxt_drv.supply_boost_drive_out = !pll_low && lvl > 3'h2;
        nxt_drv.lock_loss_flag         = !pll_low && lvl > 3'h3 && !lock_lost_in;
        nxt_drv.clamp_blank_out        = prot;
        nxt_drv.pll_discharge          = prot;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drv_ff    <= 7'h03;
            bus_en_ff <= 1'b0;
            act_ff    <= 1'b0;
        end else begin
            drv_ff    <= nxt_drv;
            bus_en_ff <= sup83;
            act_ff    <= running;
        end
    end

    assign gated_out = drv_ff;
    assign seq_state = state_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_dip;
        state_ff == SQ_ACTIVE && !sup81;
    endsequence
    sequence s_float;
        ##1 state_ff == SQ_PROTECT ##1 !drv_ff.lock_loss_flag && drv_ff.clamp_blank_out;
    endsequence

    AST_IDLE_DRIVES_OFF: assert property (
        !running |=> drv_ff[6:2] == 5'h00)
        else $error("drive released while not running");
    AST_LOW_SUPPLY_CLEARS: assert property (
        !sup83 && state_ff == SQ_STANDBY |=> !reg_ff[SS_BIT])
        else $error("soft-start bit survived low supply");
    AST_ORDER_HORIZ: assert property (
        $rose(drv_ff.horizontal_drive_out) |-> drv_ff.vertical_out_a)
        else $error("horizontal released before vertical");
    AST_ORDER_BOOST: assert property (
        $rose(drv_ff.supply_boost_drive_out) |-> drv_ff.horizontal_drive_out)
        else $error("boost released before horizontal");
    AST_DIP_PROTECT: assert property (
        s_dip |-> s_float)
        else $error("dip did not enter protection");
    AST_OVP_PROTECT: assert property (
        running && ovp |=> state_ff == SQ_PROTECT ##1 drv_ff.pll_discharge)
        else $error("over-voltage did not trip");
    AST_PLL_LOW_BLANK: assert property (
        pll_low |=> drv_ff.clamp_blank_out && drv_ff.pll_discharge
        && !drv_ff.horizontal_drive_out)
        else $error("grounded loop filter not protected");
    AST_PROTECT_FLOAT: assert property (
        state_ff == SQ_PROTECT |=> drv_ff[6:2] == 5'h00 && drv_ff.clamp_blank_out)
        else $error("protection outputs not forced");
    AST_HOLD_WHILE_CAUSE: assert property (
        state_ff == SQ_PROTECT && (ovp || !sup83) |=> state_ff == SQ_PROTECT)
        else $error("protection left with cause present");
    AST_SUPPLY_RESTART: assert property (
        state_ff == SQ_PROTECT && cause_ff == '0 && !ovp && sup83 && run_ok
        |=> state_ff == SQ_SOFTSTART)
        else $error("dip recovery did not restart");
endmodule
